// >>> logic/pwr_seq_map.svh
`ifndef PWR_SEQ_MAP_SVH
`define PWR_SEQ_MAP_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ---------------------------------------------------------------
`define CMD_REG_OFF          8'h00
`define CHAN_CTRL_REG_OFF    8'h04
`define STATUS_REG_OFF       8'h08

// ---------------------------------------------------------------
// Command register bit positions
// ---------------------------------------------------------------
`define CMD_WAKE_BIT         0
`define CMD_STANDBY_BIT      1
`define CMD_RESET_BIT        2

// ---------------------------------------------------------------
// Status register field positions
// ---------------------------------------------------------------
`define STAT_MODE_LSB        0
`define STAT_MODE_MSB        1
`define STAT_LIMP_BIT        2
`define STAT_FRAME_ERR_BIT   3
`define STAT_SETTLE_BIT      4
`define STAT_DIAG_BIT        5
`define STAT_UV_BIT          6

// ---------------------------------------------------------------
// Reset values and channel routing
// ---------------------------------------------------------------
`define CHAN_CTRL_RESET      8'h00
`define CHAN_OFF             8'h00
`define LIMP_CH_A_IDX        3
`define LIMP_CH_B_IDX        4

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_FREQ_MHZ         40
`define WAKE_SETTLE_US       200
`define WAKE_SETTLE_CYC      (`WAKE_SETTLE_US * `CLK_FREQ_MHZ)
`define SETTLE_CNT_W         14

`endif

// >>> logic/pwr_seq_pkg.sv
`include "pwr_seq_map.svh"

package pwr_seq_pkg;

    // Gray sequence: sleep -> operation -> limp -> undervoltage
    typedef enum logic [1:0] {
        MODE_SLEEP = 2'b00,
        MODE_OPER  = 2'b01,
        MODE_LIMP  = 2'b11,
        MODE_UV    = 2'b10
    } mode_e;

    typedef logic [`SETTLE_CNT_W-1:0] settle_cnt_t;

    typedef struct packed {
        mode_e       mode;
        logic [7:0]  chan_ctrl;
        logic [7:0]  chan_out;
        logic        frame_error_flag;
        logic        ack;
        logic [31:0] rdata;
        logic        diag;
    } core_s;

    typedef struct packed {
        settle_cnt_t cnt;
        logic        busy;
    } settle_s;

endpackage

// >>> logic/settle_if.sv
`timescale 1ns/1ps

interface settle_if;
    logic start;
    logic busy;

    modport ctrl  (output start, input  busy);
    modport timer (input  start, output busy);
endinterface

// >>> logic/wake_settle_timer.sv
`timescale 1ns/1ps
`include "pwr_seq_map.svh"

module wake_settle_timer #(
    parameter int unsigned SETTLE_CYCLES = `WAKE_SETTLE_CYC
) (
    input  wire logic clk_i,          // System clock
    input  wire logic rst_i,          // Synchronous reset, high
    settle_if.timer   tmr             // Start and busy
);

    pwr_seq_pkg::settle_s st_reg;
    pwr_seq_pkg::settle_s st_next;

    localparam pwr_seq_pkg::settle_cnt_t LAST = pwr_seq_pkg::settle_cnt_t'(SETTLE_CYCLES - 1);

    // ---------------------------------------------------------------
    // Settle counter
    // ---------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        if (tmr.start) begin
            st_next.busy = 1'b1;
            st_next.cnt  = '0;
        end else if (st_reg.busy) begin
            if (st_reg.cnt == LAST) begin
                st_next.busy = 1'b0;
            end else begin
                st_next.cnt = st_reg.cnt + pwr_seq_pkg::settle_cnt_t'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tmr.busy = st_reg.busy;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    property p_start_busy;
        @(posedge clk_i) disable iff (rst_i)
        tmr.start |=> st_reg.busy && st_reg.cnt == '0;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("timer not busy after start");

    property p_busy_ends;
        @(posedge clk_i) disable iff (rst_i)
        st_reg.busy && st_reg.cnt == LAST && !tmr.start |=> !st_reg.busy;
    endproperty
    a_busy_ends: assert property (p_busy_ends) else $error("timer overran");

endmodule

// >>> logic/relay_power_ctrl.sv
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "pwr_seq_map.svh"

// Functional notes
// - Power-up loads defaults, starts in sleep
// - Wake command moves sleep to operation
// - Standby command moves operation to sleep
// - Low battery supply raises undervoltage reset
// - Bus works whenever logic supply is good; writes are dropped while wake settling runs
// - Logic supply loss keeps outputs and configuration
// - Sleep clears banks; commands enter/leave only
// - High fallback input pin activates limp-home
// - Limp clears registers, routes inputs to 4/5
// - Fallback pin wakes device from standby
// - After limp-home, enter sleep (undervoltage if battery low)
// - Any reset: channels off, error flag, sleep
// - Reads during undervoltage show error flag
// - Undervoltage reset released when both supplies good
// - Reset command clears banks and diagnosis
// - Limp: reads answered, commands rejected
// - Diagnostics only at nominal battery, no limp
module relay_power_ctrl #(
    parameter int unsigned SETTLE_CYCLES = `WAKE_SETTLE_CYC
) (
    input  wire logic        clk_i,               // System clock, 40 MHz
    input  wire logic        rst_i,               // Synchronous reset, high
    input  wire logic        wb_cyc_i,            // Wishbone cycle
    input  wire logic        wb_stb_i,            // Wishbone strobe
    input  wire logic        wb_we_i,             // Wishbone write enable
    input  wire logic [7:0]  wb_adr_i,            // Wishbone byte address
    input  wire logic [3:0]  wb_sel_i,            // Wishbone byte selects
    input  wire logic [31:0] wb_dat_i,            // Wishbone write data
    output logic      [31:0] wb_dat_o,            // Wishbone read data
    output logic             wb_ack_o,            // Wishbone acknowledge
    input  wire logic        battery_ok_i,        // Battery supply above UV threshold
    input  wire logic        battery_nominal_i,   // Battery supply in nominal range
    input  wire logic        logic_ok_i,          // Logic supply above UV threshold
    input  wire logic        fallback_input_pin_i,// Limp-home request
    input  wire logic        in1_i,               // Direct input 1
    input  wire logic        in2_i,               // Direct input 2
    output logic      [7:0]  chan_o,              // Channel on states
    output logic      [1:0]  mode_o,              // Current power mode
    output logic             diag_en_o,           // Diagnostics enabled
    output logic             frame_error_flag_o   // Frame error flag
);

    pwr_seq_pkg::core_s r_reg;
    pwr_seq_pkg::core_s r_next;

    settle_if settle ();

    logic acc;
    logic wr;
    logic cmd_ok;

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction

    assign acc    = wb_cyc_i && wb_stb_i && !r_reg.ack;
    assign wr     = acc && wb_we_i && wb_sel_i[0];
    // Frames are dropped while settling, in limp and without logic supply
    assign cmd_ok = logic_ok_i && !settle.busy;

    // ---------------------------------------------------------------
    // Status word
    // ---------------------------------------------------------------
    function automatic logic [31:0] status_word(input pwr_seq_pkg::core_s s, input logic busy);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`STAT_MODE_MSB:`STAT_MODE_LSB] = s.mode;
        w[`STAT_LIMP_BIT]      = (s.mode == pwr_seq_pkg::MODE_LIMP);
        w[`STAT_FRAME_ERR_BIT] = s.frame_error_flag;
        w[`STAT_SETTLE_BIT]    = busy;
        w[`STAT_DIAG_BIT]      = s.diag;
        w[`STAT_UV_BIT]        = (s.mode == pwr_seq_pkg::MODE_UV);
        return w;
    endfunction

    // ---------------------------------------------------------------
    // Mode sequencing and register bank
    // ---------------------------------------------------------------
    always_comb begin
        r_next       = r_reg;
        r_next.ack   = acc;
        settle.start = 1'b0;

        // Bus read data
        if (acc && !wb_we_i) begin
            if (hit(wb_adr_i, `CHAN_CTRL_REG_OFF)) begin
                r_next.rdata = {24'h00_0000, r_reg.chan_ctrl};
            end else if (hit(wb_adr_i, `STATUS_REG_OFF)) begin
                r_next.rdata = status_word(r_reg, settle.busy);
            end else begin
                r_next.rdata = 32'h0000_0000;
            end
        end else if (acc) begin
            r_next.rdata = 32'h0000_0000;
        end

        // Error flag clear by write-one, before any set below
        if (wr && cmd_ok && hit(wb_adr_i, `STATUS_REG_OFF) && wb_dat_i[`STAT_FRAME_ERR_BIT]
            && r_reg.mode != pwr_seq_pkg::MODE_LIMP && r_reg.mode != pwr_seq_pkg::MODE_UV) begin
            r_next.frame_error_flag = 1'b0;
        end

        case (r_reg.mode)
            pwr_seq_pkg::MODE_UV: begin
                r_next.chan_ctrl = `CHAN_CTRL_RESET;
                if (battery_ok_i && logic_ok_i) begin
                    r_next.mode = pwr_seq_pkg::MODE_SLEEP;
                end
            end
            pwr_seq_pkg::MODE_LIMP: begin
                r_next.chan_ctrl = `CHAN_CTRL_RESET;
                if (!battery_ok_i) begin
                    r_next.mode             = pwr_seq_pkg::MODE_UV;
                    r_next.frame_error_flag = 1'b1;
                end else if (!fallback_input_pin_i) begin
                    r_next.mode = pwr_seq_pkg::MODE_SLEEP;
                end
            end
            pwr_seq_pkg::MODE_SLEEP,
            pwr_seq_pkg::MODE_OPER: begin
                if (!battery_ok_i) begin
                    r_next.mode             = pwr_seq_pkg::MODE_UV;
                    r_next.chan_ctrl        = `CHAN_CTRL_RESET;
                    r_next.frame_error_flag = 1'b1;
                end else if (fallback_input_pin_i) begin
                    r_next.mode      = pwr_seq_pkg::MODE_LIMP;
                    r_next.chan_ctrl = `CHAN_CTRL_RESET;
                end else if (wr && cmd_ok && hit(wb_adr_i, `CMD_REG_OFF)) begin
                    if (wb_dat_i[`CMD_RESET_BIT]) begin
                        r_next.mode             = pwr_seq_pkg::MODE_SLEEP;
                        r_next.chan_ctrl        = `CHAN_CTRL_RESET;
                        r_next.frame_error_flag = 1'b1;
                    end else if (wb_dat_i[`CMD_WAKE_BIT] && r_reg.mode == pwr_seq_pkg::MODE_SLEEP) begin
                        r_next.mode  = pwr_seq_pkg::MODE_OPER;
                        settle.start = 1'b1;
                    end else if (wb_dat_i[`CMD_STANDBY_BIT] && r_reg.mode == pwr_seq_pkg::MODE_OPER) begin
                        r_next.mode      = pwr_seq_pkg::MODE_SLEEP;
                        r_next.chan_ctrl = `CHAN_CTRL_RESET;
                    end
                end else if (wr && cmd_ok && hit(wb_adr_i, `CHAN_CTRL_REG_OFF)
                             && r_reg.mode == pwr_seq_pkg::MODE_OPER) begin
                    r_next.chan_ctrl = wb_dat_i[7:0];
                end
            end
            default: begin
                r_next.mode      = pwr_seq_pkg::MODE_SLEEP;
                r_next.chan_ctrl = `CHAN_CTRL_RESET;
            end
        endcase

        // Channel drive follows the new mode; kept regardless of logic supply
        case (r_next.mode)
            pwr_seq_pkg::MODE_OPER: begin
                r_next.chan_out = r_next.chan_ctrl;
            end
            pwr_seq_pkg::MODE_LIMP: begin
                r_next.chan_out = `CHAN_OFF;
                r_next.chan_out[`LIMP_CH_A_IDX] = in1_i;
                r_next.chan_out[`LIMP_CH_B_IDX] = in2_i;
            end
            default: begin
                r_next.chan_out = `CHAN_OFF;
            end
        endcase

        r_next.diag = battery_nominal_i && (r_next.mode == pwr_seq_pkg::MODE_OPER);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_reg.mode             <= pwr_seq_pkg::MODE_SLEEP;
            r_reg.chan_ctrl        <= `CHAN_CTRL_RESET;
            r_reg.chan_out         <= `CHAN_OFF;
            r_reg.frame_error_flag <= 1'b1;
            r_reg.ack              <= 1'b0;
            r_reg.rdata            <= 32'h0000_0000;
            r_reg.diag             <= 1'b0;
        end else begin
            r_reg <= r_next;
        end
    end

    wake_settle_timer #(
        .SETTLE_CYCLES (SETTLE_CYCLES)
    ) u_settle (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tmr   (settle.timer)
    );

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign wb_dat_o           = r_reg.rdata;
    assign wb_ack_o           = r_reg.ack;
    assign chan_o             = r_reg.chan_out;
    assign mode_o             = r_reg.mode;
    assign diag_en_o          = r_reg.diag;
    assign frame_error_flag_o = r_reg.frame_error_flag;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    property p_reset_sleep;
        @(posedge clk_i)
        rst_i |=> r_reg.mode == pwr_seq_pkg::MODE_SLEEP && r_reg.frame_error_flag && chan_o == 8'h00;
    endproperty
    a_reset_sleep: assert property (p_reset_sleep) else $error("reset did not give sleep");

    property p_wake;
        @(posedge clk_i) disable iff (rst_i)
        wr && cmd_ok && hit(wb_adr_i, `CMD_REG_OFF) && wb_dat_i[1:0] == 2'h1 && !wb_dat_i[2]
        && r_reg.mode == pwr_seq_pkg::MODE_SLEEP && battery_ok_i && !fallback_input_pin_i
        |=> r_reg.mode == pwr_seq_pkg::MODE_OPER && settle.busy;
    endproperty
    a_wake: assert property (p_wake) else $error("wake command not taken");

    property p_standby;
        @(posedge clk_i) disable iff (rst_i)
        wr && cmd_ok && hit(wb_adr_i, `CMD_REG_OFF) && wb_dat_i[2:1] == 2'h1
        && r_reg.mode == pwr_seq_pkg::MODE_OPER && battery_ok_i && !fallback_input_pin_i
        |=> r_reg.mode == pwr_seq_pkg::MODE_SLEEP ##1 chan_o == 8'h00;
    endproperty
    a_standby: assert property (p_standby) else $error("standby command not taken");

    property p_uv_enter;
        @(posedge clk_i) disable iff (rst_i)
        !battery_ok_i |=> r_reg.mode == pwr_seq_pkg::MODE_UV && r_reg.frame_error_flag;
    endproperty
    a_uv_enter: assert property (p_uv_enter) else $error("undervoltage not entered");

    property p_uv_release;
        @(posedge clk_i) disable iff (rst_i)
        r_reg.mode == pwr_seq_pkg::MODE_UV && battery_ok_i && logic_ok_i
        |=> r_reg.mode == pwr_seq_pkg::MODE_SLEEP && r_reg.frame_error_flag;
    endproperty
    a_uv_release: assert property (p_uv_release) else $error("undervoltage release wrong");

    property p_uv_hold;
        @(posedge clk_i) disable iff (rst_i)
        r_reg.mode == pwr_seq_pkg::MODE_UV && !logic_ok_i |=> r_reg.mode == pwr_seq_pkg::MODE_UV;
    endproperty
    a_uv_hold: assert property (p_uv_hold) else $error("undervoltage released early");

    property p_limp_enter;
        @(posedge clk_i) disable iff (rst_i)
        battery_ok_i && fallback_input_pin_i && r_reg.mode != pwr_seq_pkg::MODE_UV
        |=> r_reg.mode == pwr_seq_pkg::MODE_LIMP && r_reg.chan_ctrl == 8'h00;
    endproperty
    a_limp_enter: assert property (p_limp_enter) else $error("limp-home not entered");

    property p_limp_route;
        @(posedge clk_i) disable iff (rst_i)
        r_reg.mode == pwr_seq_pkg::MODE_LIMP
        |-> chan_o == {3'h0, $past(in2_i), $past(in1_i), 3'h0};
    endproperty
    a_limp_route: assert property (p_limp_route) else $error("limp routing wrong");

    property p_limp_exit;
        @(posedge clk_i) disable iff (rst_i)
        r_reg.mode == pwr_seq_pkg::MODE_LIMP && battery_ok_i && !fallback_input_pin_i
        |=> r_reg.mode == pwr_seq_pkg::MODE_SLEEP;
    endproperty
    a_limp_exit: assert property (p_limp_exit) else $error("limp exit not to sleep");

    property p_limp_reject;
        @(posedge clk_i) disable iff (rst_i)
        r_reg.mode == pwr_seq_pkg::MODE_LIMP && fallback_input_pin_i && battery_ok_i
        |=> r_reg.mode == pwr_seq_pkg::MODE_LIMP && $stable(r_reg.chan_ctrl);
    endproperty
    a_limp_reject: assert property (p_limp_reject) else $error("command taken in limp");

    property p_reset_cmd;
        @(posedge clk_i) disable iff (rst_i)
        wr && cmd_ok && hit(wb_adr_i, `CMD_REG_OFF) && wb_dat_i[`CMD_RESET_BIT] && battery_ok_i
        && !fallback_input_pin_i && r_reg.mode != pwr_seq_pkg::MODE_LIMP && r_reg.mode != pwr_seq_pkg::MODE_UV
        |=> r_reg.mode == pwr_seq_pkg::MODE_SLEEP && r_reg.chan_ctrl == 8'h00 && r_reg.frame_error_flag
        ##1 chan_o == 8'h00;
    endproperty
    a_reset_cmd: assert property (p_reset_cmd) else $error("reset command not applied");

    property p_settle_block;
        @(posedge clk_i) disable iff (rst_i)
        wr && settle.busy && hit(wb_adr_i, `CHAN_CTRL_REG_OFF) && battery_ok_i && !fallback_input_pin_i
        |=> $stable(r_reg.chan_ctrl);
    endproperty
    a_settle_block: assert property (p_settle_block) else $error("frame taken while settling");

    property p_keep_no_logic;
        @(posedge clk_i) disable iff (rst_i)
        !logic_ok_i && battery_ok_i && !fallback_input_pin_i && r_reg.mode == pwr_seq_pkg::MODE_OPER
        |=> r_reg.mode == pwr_seq_pkg::MODE_OPER && $stable(r_reg.chan_ctrl);
    endproperty
    a_keep_no_logic: assert property (p_keep_no_logic) else $error("state lost without logic supply");

    property p_diag;
        @(posedge clk_i) disable iff (rst_i)
        diag_en_o |-> r_reg.mode == pwr_seq_pkg::MODE_OPER && $past(battery_nominal_i);
    endproperty
    a_diag: assert property (p_diag) else $error("diagnostics enabled wrongly");

    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

    property p_ack_answer;
        @(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not acknowledged");

    property p_oper_drive;
        @(posedge clk_i) disable iff (rst_i)
        r_reg.mode == pwr_seq_pkg::MODE_OPER |-> chan_o == r_reg.chan_ctrl;
    endproperty
    a_oper_drive: assert property (p_oper_drive) else $error("channels differ from control");

    property p_sleep_clear;
        @(posedge clk_i) disable iff (rst_i)
        r_reg.mode == pwr_seq_pkg::MODE_SLEEP || r_reg.mode == pwr_seq_pkg::MODE_UV
        |-> chan_o == 8'h00 && r_reg.chan_ctrl == 8'h00;
    endproperty
    a_sleep_clear: assert property (p_sleep_clear) else $error("banks not cleared in sleep");

    property p_no_diag;
        @(posedge clk_i) disable iff (rst_i)
        r_reg.mode != pwr_seq_pkg::MODE_OPER |-> !diag_en_o;
    endproperty
    a_no_diag: assert property (p_no_diag) else $error("diagnostics on outside operation");

    property p_uv_flag;
        @(posedge clk_i) disable iff (rst_i)
        r_reg.mode == pwr_seq_pkg::MODE_UV |-> frame_error_flag_o;
    endproperty
    a_uv_flag: assert property (p_uv_flag) else $error("error flag clear in undervoltage");

endmodule

// >>> verif/host_model.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Host controller driving the register bus
// ---------------------------------------------------------------
module host_model #(
    parameter int SETTLE = 20
) (
    input  wire logic        clk_i,   // System clock
    input  wire logic        ack_i,   // Slave acknowledge
    input  wire logic [31:0] dat_i,   // Slave read data
    output logic             cyc_o,   // Cycle
    output logic             stb_o,   // Strobe
    output logic             we_o,    // Write enable
    output logic      [7:0]  adr_o,   // Byte address
    output logic      [3:0]  sel_o,   // Byte selects
    output logic      [31:0] dat_o    // Write data
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end

    // One classic cycle; idle lines carry the inverse of the last value
    task automatic access(input logic we, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q, output logic to);
        int n;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= we;
        adr_o <= a;
        sel_o <= 4'hF;
        dat_o <= d;
        to = 1'b1;
        q  = 32'h0;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (ack_i === 1'b1) begin
                q  = dat_i;
                to = 1'b0;
                break;
            end
        end
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o  <= ~we;
        adr_o <= ~a;
        sel_o <= 4'h0;
        dat_o <= ~d;
    endtask

    // Quiet time after a wake command
    task automatic settle_wait();
        repeat (SETTLE + 2) @(posedge clk_i);
    endtask
endmodule

// >>> verif/tb_relay_driver_power_mode_control.sv
`timescale 1ns/1ps
`include "pwr_seq_map.svh"

module tb_relay_driver_power_mode_control;
    logic clk_i = 1'b0, rst_i = 1'b1;
    logic cyc, stb, we, ack;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic battery_ok_i = 1'b1, battery_nominal_i = 1'b1, logic_ok_i = 1'b1;
    logic fallback_input_pin_i = 1'b0, in1_i = 1'b0, in2_i = 1'b0;
    logic [7:0] chan_o;
    logic [1:0] mode_o;
    logic diag_en_o, frame_error_flag_o;
    int miscompares = 0;
    int total_checks = 0;

    always #12.5 clk_i = ~clk_i;

    relay_power_ctrl #(.SETTLE_CYCLES(20)) relay_power_ctrl_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .battery_ok_i(battery_ok_i), .battery_nominal_i(battery_nominal_i),
        .logic_ok_i(logic_ok_i), .fallback_input_pin_i(fallback_input_pin_i),
        .in1_i(in1_i), .in2_i(in2_i), .chan_o(chan_o), .mode_o(mode_o),
        .diag_en_o(diag_en_o), .frame_error_flag_o(frame_error_flag_o));

    host_model #(.SETTLE(20)) host_model_i (
        .clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
        .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic to;
        host_model_i.access(w, a, d, q, to);
        if (to) begin
            miscompares++;
            $display("unexpected at %0t: ack %h expected %h", $time, 1'b0, 1'b1);
            end_of_test();
        end
        @(negedge clk_i);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic wake_up();
        wb(1'b1, `CMD_REG_OFF, 32'h1);
        host_model_i.settle_wait();
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        chk(32'(mode_o), 32'h0);
        chk(32'(chan_o), 32'h0);
        chk(32'(frame_error_flag_o), 32'h1);
        wb(1'b0, `STATUS_REG_OFF, 32'h0);
        chk(q & 32'h7F, 32'h08);
        wb(1'b1, `STATUS_REG_OFF, 32'h8);
        chk(32'(frame_error_flag_o), 32'h0);
    endtask

    task automatic t_wake();
        wb(1'b1, `CMD_REG_OFF, 32'h1);
        chk(32'(mode_o), 32'h1);
        wb(1'b0, `STATUS_REG_OFF, 32'h0);
        chk(q & 32'h10, 32'h10);
        wb(1'b1, `CHAN_CTRL_REG_OFF, 32'hA5);
        wb(1'b0, `CHAN_CTRL_REG_OFF, 32'h0);
        chk(q & 32'hFF, 32'h0);
        host_model_i.settle_wait();
        wb(1'b1, `CHAN_CTRL_REG_OFF, 32'hA5);
        chk(32'(chan_o), 32'hA5);
        chk(32'(diag_en_o), 32'h1);
        @(posedge clk_i);
        battery_nominal_i <= 1'b0;
        tick(2);
        chk(32'(diag_en_o), 32'h0);
        @(posedge clk_i);
        battery_nominal_i <= 1'b1;
    endtask

    task automatic t_logic_loss();
        @(posedge clk_i);
        logic_ok_i <= 1'b0;
        wb(1'b1, `CMD_REG_OFF, 32'h2);
        chk(32'(mode_o), 32'h1);
        chk(32'(chan_o), 32'hA5);
        @(posedge clk_i);
        logic_ok_i <= 1'b1;
        wb(1'b1, `CMD_REG_OFF, 32'h2);
        chk(32'(mode_o), 32'h0);
        chk(32'(chan_o), 32'h0);
        wb(1'b0, `CHAN_CTRL_REG_OFF, 32'h0);
        chk(q & 32'hFF, 32'h0);
    endtask

    task automatic t_reset_cmd();
        wake_up();
        wb(1'b1, `CHAN_CTRL_REG_OFF, 32'h3C);
        chk(32'(chan_o), 32'h3C);
        wb(1'b1, `CMD_REG_OFF, 32'h7);
        chk(32'(mode_o), 32'h0);
        chk(32'(chan_o), 32'h0);
        chk(32'(frame_error_flag_o), 32'h1);
    endtask

    task automatic t_limp();
        @(posedge clk_i);
        in1_i <= 1'b1;
        fallback_input_pin_i <= 1'b1;
        tick(3);
        chk(32'(mode_o), 32'h3);
        chk(32'(chan_o), 32'h08);
        @(posedge clk_i);
        in1_i <= 1'b0;
        in2_i <= 1'b1;
        tick(3);
        chk(32'(chan_o), 32'h10);
        wb(1'b1, `CMD_REG_OFF, 32'h1);
        chk(32'(mode_o), 32'h3);
        wb(1'b0, `STATUS_REG_OFF, 32'h0);
        chk(q & 32'h07, 32'h07);
        @(posedge clk_i);
        fallback_input_pin_i <= 1'b0;
        in2_i <= 1'b0;
        tick(3);
        chk(32'(mode_o), 32'h0);
        chk(32'(chan_o), 32'h0);
    endtask

    task automatic t_uv();
        wake_up();
        wb(1'b1, `CHAN_CTRL_REG_OFF, 32'hFF);
        wb(1'b1, `STATUS_REG_OFF, 32'h8);
        @(posedge clk_i);
        battery_ok_i <= 1'b0;
        tick(3);
        chk(32'(mode_o), 32'h2);
        chk(32'(chan_o), 32'h0);
        chk(32'(frame_error_flag_o), 32'h1);
        wb(1'b0, `STATUS_REG_OFF, 32'h0);
        chk(q & 32'h48, 32'h48);
        @(posedge clk_i);
        battery_ok_i <= 1'b1;
        logic_ok_i <= 1'b0;
        tick(3);
        chk(32'(mode_o), 32'h2);
        @(posedge clk_i);
        logic_ok_i <= 1'b1;
        tick(3);
        chk(32'(mode_o), 32'h0);
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        t_reset();
        t_wake();
        t_logic_loss();
        t_reset_cmd();
        t_limp();
        t_uv();
        end_of_test();
    end
endmodule
